// ### logic/sbo_alu_if.sv
`timescale 1ns/1ps
interface sbo_alu_if;
    import sbo_pkg::*;
    sbo_op_type op;
    logic [4:0] pos;
    logic [23:0] operand;
    logic [23:0] result;
    logic sign;
    logic zero;
    modport ctrl (output op, output pos, output operand,
                  input result, input sign, input zero);
    modport alu (input op, input pos, input operand,
                 output result, output sign, output zero);
endinterface

// ### logic/sbo_bit_alu.sv
`timescale 1ns/1ps
module sbo_bit_alu
    import sbo_pkg::*;
(
    sbo_alu_if.alu a
);
    function automatic logic [23:0] onehot(input logic [4:0] p);
        onehot = 24'h000001 << p;
    endfunction

    wire [23:0] mask = onehot(a.pos);
    wire [23:0] res_clr = a.operand & ~mask; // (RULE1)
    wire [23:0] res_inv = a.operand ^ mask; // (RULE2)
    wire [23:0] res_set = a.operand | mask; // (RULE3)

    assign a.result = (a.op == SBO_OP_CLR) ? res_clr :
                      (a.op == SBO_OP_INV) ? res_inv : res_set;
    assign a.sign = a.result[SIGN_BIT]; // (RULE7)
    assign a.zero = (a.result == 24'h000000); // (RULE7)
endmodule // sbo_bit_alu

// ### logic/sbo_pkg.sv
package sbo_pkg;
    localparam int WORD_W = 24;
    localparam int POS_W = 5;
    localparam int SEL_W = 2;
    localparam logic [4:0] POS_MAX = 5'h17;
    localparam int SIGN_BIT = 23;
    localparam int INSTR_BYTES = 2;
    localparam int INSTR_CYCLES = 2;
    localparam logic [23:0] ACC_RESET = 24'h000000;
    localparam logic [7:0] OPC_CLR = 8'hA0;
    localparam logic [7:0] OPC_INV = 8'hA1;
    localparam logic [7:0] OPC_SET = 8'hA2;
    localparam logic [1:0] ACC_X = 2'h0;
    localparam logic [1:0] ACC_Y = 2'h1;
    localparam logic [1:0] ACC_Z = 2'h2;
    localparam logic [1:0] ACC_R = 2'h3;
    localparam int ACC_COUNT = 4;
    localparam int ARG_DST_LSB = 5;
    localparam int ARG_POS_LSB = 0;
    localparam logic SIGN_RESET = 1'b0;
    localparam logic ZERO_RESET = 1'b1;

    typedef enum logic [1:0] {
        SBO_OP_CLR,
        SBO_OP_INV,
        SBO_OP_SET
    } sbo_op_type;

    typedef enum logic {
        SBO_IDLE,
        SBO_EXEC
    } sbo_state_type;
endpackage

// ### logic/sbo_single_bit_ops.sv
`timescale 1ns/1ps
// Operation
// (RULE1) Bit clear forces selected destination bit to zero, others kept.
// (RULE2) Bit invert complements selected destination bit, writes it back.
// (RULE3) Bit set forces selected destination bit to one, others kept.
// (RULE4) Destination is one of four working registers; position 0 to 23.
// (RULE5) Instruction is two bytes long and completes in two cycles.
// (RULE6) Sign and zero flags update from the result; no other flags.
// (RULE7) Sign is result bit 23; zero set when all 24 bits zero.
module sbo_single_bit_ops
    import sbo_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Instruction in, two bytes
    input wire logic instr_valid_i,
    input wire logic [7:0] instr_op_i,
    input wire logic [7:0] instr_arg_i,
    // Status
    output logic busy_o,
    output logic done_o,
    output logic illegal_o,
    // Working registers and flags
    output logic [23:0] reg_x_o,
    output logic [23:0] reg_y_o,
    output logic [23:0] reg_z_o,
    output logic [23:0] reg_r_o,
    output logic sign_o,
    output logic zero_o
);
    sbo_alu_if alu_bus ();

    sbo_state_type state;
    sbo_state_type next_state;
    logic [23:0] working_register [ACC_COUNT];
    logic [23:0] next_working_register [ACC_COUNT];
    sbo_op_type held_op;
    sbo_op_type next_held_op;
    logic [1:0] held_dst;
    logic [1:0] next_held_dst;
    logic [4:0] held_pos;
    logic [4:0] next_held_pos;
    logic done;
    logic next_done;
    logic illegal;
    logic next_illegal;
    logic sign;
    logic next_sign;
    logic zero;
    logic next_zero;

    // Opcode byte is one of the three bit operations
    function automatic logic is_bit_op(input logic [7:0] code);
        is_bit_op = (code == OPC_CLR) || (code == OPC_INV)
                    || (code == OPC_SET);
    endfunction

    // Unknown codes fall through to set; start never lets them run
    function automatic sbo_op_type decode_op(input logic [7:0] code);
        if (code == OPC_CLR)
            decode_op = SBO_OP_CLR;
        else if (code == OPC_INV)
            decode_op = SBO_OP_INV;
        else
            decode_op = SBO_OP_SET;
    endfunction

    // Argument byte: destination field above the position field
    function automatic logic [1:0] dest_field(input logic [7:0] arg);
        dest_field = arg[ARG_DST_LSB +: SEL_W];
    endfunction

    function automatic logic [4:0] pos_field(input logic [7:0] arg);
        pos_field = arg[ARG_POS_LSB +: POS_W];
    endfunction

    function automatic logic pos_in_range(input logic [4:0] p);
        pos_in_range = (p <= POS_MAX);
    endfunction

    wire [1:0] arg_dst = dest_field(instr_arg_i);
    wire [4:0] arg_pos = pos_field(instr_arg_i);
    wire op_known = is_bit_op(instr_op_i);
    wire pos_ok = pos_in_range(arg_pos); // (RULE4)
    wire idle = (state == SBO_IDLE);
    wire accept = idle && instr_valid_i; // (RULE5)
    wire legal = op_known && pos_ok;
    wire start = accept && legal;
    wire reject = accept && !legal;
    wire finish = (state == SBO_EXEC); // (RULE5)

    assign alu_bus.op = held_op;
    assign alu_bus.pos = held_pos;
    assign alu_bus.operand = working_register[held_dst]; // (RULE4)

    sbo_bit_alu u_alu (
        .a(alu_bus.alu)
    );

    // Cycle 1 latches the instruction, cycle 2 writes back
    always_comb
    begin
        next_state = state;
        next_held_op = held_op;
        next_held_dst = held_dst;
        next_held_pos = held_pos;
        case (state)
            SBO_IDLE:
            begin
                if (start)
                begin
                    next_state = SBO_EXEC; // (RULE5)
                    next_held_op = decode_op(instr_op_i);
                    next_held_dst = arg_dst;
                    next_held_pos = arg_pos;
                end
            end
            SBO_EXEC:
            begin
                next_state = SBO_IDLE; // (RULE5)
            end
            default:
            begin
                next_state = SBO_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state <= SBO_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            held_op <= SBO_OP_CLR;
            held_dst <= ACC_X;
            held_pos <= 5'h00;
        end
        else
        begin
            held_op <= next_held_op;
            held_dst <= next_held_dst;
            held_pos <= next_held_pos;
        end
    end

    // Only the held destination is rewritten, the others keep
    always_comb
    begin
        for (int i = 0; i < ACC_COUNT; i++)
            next_working_register[i] = working_register[i];
        if (finish)
            next_working_register[held_dst] = alu_bus.result; // (RULE1)
    end

    // Sign and zero are the only flags this block drives
    always_comb
    begin
        next_sign = sign;
        next_zero = zero;
        if (finish)
        begin
            next_sign = alu_bus.sign; // (RULE6)
            next_zero = alu_bus.zero; // (RULE6)
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < ACC_COUNT; i++)
                working_register[i] <= ACC_RESET;
        end
        else
        begin
            for (int i = 0; i < ACC_COUNT; i++)
                working_register[i] <= next_working_register[i];
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            sign <= SIGN_RESET;
            zero <= ZERO_RESET;
        end
        else
        begin
            sign <= next_sign;
            zero <= next_zero;
        end
    end

    // Pulses follow the edge that writes back or refuses
    always_comb
    begin
        next_done = finish;
        next_illegal = reject;
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            done <= 1'b0;
            illegal <= 1'b0;
        end
        else
        begin
            done <= next_done;
            illegal <= next_illegal;
        end
    end

    assign busy_o = (state == SBO_EXEC);
    assign done_o = done;
    assign illegal_o = illegal;
    assign reg_x_o = working_register[ACC_X];
    assign reg_y_o = working_register[ACC_Y];
    assign reg_z_o = working_register[ACC_Z];
    assign reg_r_o = working_register[ACC_R];
    assign sign_o = sign;
    assign zero_o = zero;
endmodule // sbo_single_bit_ops

// ### tb/sbo_checker.sv
`timescale 1ns/1ps
module sbo_checker
    import sbo_pkg::*;
(
    input wire logic mclk_i, rst_n_i, instr_valid_i,
    input wire logic busy_o, done_o, illegal_o, sign_o, zero_o,
    input wire logic [7:0] instr_op_i, instr_arg_i,
    input wire logic [23:0] reg_x_o, reg_y_o, reg_z_o, reg_r_o
);
    logic [23:0] v, m;
    logic [1:0] d;
    logic [23:0] rg [4];
    assign rg = '{reg_x_o, reg_y_o, reg_z_o, reg_r_o};
    wire [23:0] p = rg[d];
    wire tk = instr_valid_i && !busy_o;
    wire ok = instr_op_i inside {OPC_CLR, OPC_INV, OPC_SET}
        && instr_arg_i[4:0] <= POS_MAX;
    // Snapshot of the target before the write-back
    always_ff @(posedge mclk_i)
        if (tk)
        begin
            d <= instr_arg_i[6:5];
            v <= rg[instr_arg_i[6:5]];
            m <= 24'h1 << instr_arg_i[4:0];
        end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence go(o);
        tk && ok && instr_op_i == o;
    endsequence
    clr_a: assert property (go(OPC_CLR) |-> ##2 p == (v & ~m))
        else $error("clr");
    inv_a: assert property (go(OPC_INV) |-> ##2 p == (v ^ m))
        else $error("inv");
    set_a: assert property (go(OPC_SET) |-> ##2 p == (v | m))
        else $error("set");
    bad_a: assert property (tk && !ok |=> illegal_o)
        else $error("illegal");
    busy_a: assert property (tk && ok |=> busy_o ##1 !busy_o)
        else $error("busy");
    done_a: assert property (tk && ok |-> ##2 done_o)
        else $error("done");
    flag_a: assert property (tk && ok |-> ##2
        sign_o == p[23] && zero_o == (p == 24'h0)) else $error("flags");
    hold_a: assert property (!busy_o |=> $stable(reg_x_o)
        && $stable(reg_y_o) && $stable(reg_z_o) && $stable(reg_r_o)
        && $stable(sign_o) && $stable(zero_o)) else $error("hold");
endmodule // sbo_checker
bind sbo_single_bit_ops sbo_checker chk_u (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i),
    .busy_o(busy_o),
    .done_o(done_o),
    .illegal_o(illegal_o),
    .sign_o(sign_o),
    .zero_o(zero_o),
    .instr_op_i(instr_op_i),
    .instr_arg_i(instr_arg_i),
    .reg_x_o(reg_x_o),
    .reg_y_o(reg_y_o),
    .reg_z_o(reg_z_o),
    .reg_r_o(reg_r_o)
);

// ### tb/sbo_single_bit_ops_tb.sv
`timescale 1ns/1ps
module sbo_single_bit_ops_tb import sbo_pkg::*;;
    logic mclk_i = 0, rst_n_i = 0, instr_valid_i = 0;
    logic [7:0] instr_op_i = 8'h00, instr_arg_i = 8'h00;
    logic busy_o, done_o, illegal_o, sign_o, zero_o;
    logic [23:0] reg_x_o, reg_y_o, reg_z_o, reg_r_o, fr = 24'h0;
    logic [23:0] g [4], e [4] = '{default: 24'h0};
    logic [15:0] cs [6] = '{16'hA217, 16'hA137, 16'hA017, 16'hA218,
        16'hA300, 16'hA260};
    logic [31:0] r;
    int n_fail = 0, n_tests = 0, seed = 8606;
    always #5 mclk_i = ~mclk_i;
    sbo_single_bit_ops dut_u (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .instr_valid_i(instr_valid_i),
        .instr_op_i(instr_op_i),
        .instr_arg_i(instr_arg_i),
        .busy_o(busy_o),
        .done_o(done_o),
        .illegal_o(illegal_o),
        .reg_x_o(reg_x_o),
        .reg_y_o(reg_y_o),
        .reg_z_o(reg_z_o),
        .reg_r_o(reg_r_o),
        .sign_o(sign_o),
        .zero_o(zero_o)
    );
    assign g = '{reg_x_o, reg_y_o, reg_z_o, reg_r_o};
    task chk(input logic [23:0] a, b);
        n_tests++;
        if (a !== b)
        begin
            n_fail++;
            $display("ERROR %0t got %h exp %h", $time, a, b);
        end
    endtask
    task chk_bit(input logic a, b);
        n_tests++;
        if (a !== b)
        begin
            n_fail++;
            $display("ERROR %0t flag got %b exp %b", $time, a, b);
        end
    endtask
    function automatic logic [23:0] f(logic [7:0] o, logic [23:0] a,
        logic [4:0] p);
        return o == OPC_CLR ? a & ~(24'h1 << p)
            : o == OPC_INV ? a ^ (24'h1 << p) : a | (24'h1 << p);
    endfunction
    task complete_run;
        $display("fail %0d of %0d", n_fail, n_tests);
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Valid held into the busy cycle: that copy must be ignored
    task run(input logic [7:0] o, a);
        logic ok;
        ok = o inside {OPC_CLR, OPC_INV, OPC_SET} && a[4:0] <= POS_MAX;
        if (ok)
        begin
            e[a[6:5]] = f(o, e[a[6:5]], a[4:0]);
            fr = e[a[6:5]];
        end
        @(posedge mclk_i);
        instr_valid_i <= 1'b1;
        instr_op_i <= o;
        instr_arg_i <= a;
        @(posedge mclk_i);
        #1 chk_bit(illegal_o, !ok);
        chk_bit(busy_o, ok);
        @(posedge mclk_i);
        instr_valid_i <= 1'b0;
        #1 chk_bit(done_o, ok);
        foreach (e[i])
            chk(g[i], e[i]);
        chk_bit(sign_o, fr[23]);
        chk_bit(zero_o, fr == 24'h0);
    endtask
    initial
    begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        foreach (cs[i])
            run(cs[i][15:8], cs[i][7:0]);
        // Mid-run reset clears all working registers and sign, and sets zero
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        e = '{default: 24'h0};
        fr = 24'h0;
        #1 chk_bit(busy_o, 1'b0);
        foreach (e[i])
            chk(g[i], e[i]);
        chk_bit(sign_o, 1'b0);
        chk_bit(zero_o, 1'b1);
        repeat (200)
        begin
            r = $random(seed);
            run(8'hA0 + r[1:0], r[15:8]);
        end
        complete_run;
    end
    initial
    begin
        #20000;
        n_fail++;
        complete_run;
    end
endmodule // sbo_single_bit_ops_tb
